//--- src/amp_pwr_pkg.sv
/*
  Shared constants and types for the amplifier power state controller:
  register offsets, control and interrupt bit positions, state codes,
  transition timing and the rail monitor carrier.
  Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package amp_pwr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [7:0] OFS_CTRL       = 8'h00;  // enable, soft reset, recovery modes
  localparam logic [7:0] OFS_STATUS     = 8'h04;  // state and rail view, read only
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;  // sticky, write one to clear
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h0C;  // one lets the flag reach o_irq

  // control register fields
  localparam int CTRL_EN_BIT        = 0;  // global enable
  localparam int CTRL_SOFT_RST_BIT  = 1;  // write one: soft reset, reads zero
  localparam int CTRL_BAT_AUTO_BIT  = 2;  // battery_rail_auto_recover
  localparam int CTRL_PWR_AUTO_BIT  = 3;  // power_rail_auto_recover
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // interrupt register fields
  localparam int IRQ_W            = 5;
  localparam int IRQ_UP_BIT       = 0;  // power_up_done_irq
  localparam int IRQ_DN_BIT       = 1;  // power_down_done_irq
  localparam int IRQ_BAT_BIT      = 2;  // battery_rail_low_shutdown_irq
  localparam int IRQ_PWR_BIT      = 3;  // power_rail_low_shutdown_irq
  localparam int IRQ_TRIM_BIT     = 4;  // trim load failure
  localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_TRANS_NS    = 1000;  // soft shutdown <-> active ramp time
  localparam int TRANS_CYCLES  = (T_TRANS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // power states, binary codes
  typedef enum logic [2:0] {
    ST_HW_SHDN = 3'h0,  // hardware shutdown, global reset held
    ST_TRIM    = 3'h1,  // leaving hardware shutdown, trim loading
    ST_SW_SHDN = 3'h2,  // software shutdown, only the bus alive
    ST_PWR_UP  = 3'h3,  // ramping toward active
    ST_ACTIVE  = 3'h4,  // playback possible
    ST_PWR_DN  = 3'h5   // ramping toward software shutdown
  } pwr_state_t;

  // undervoltage_lockout monitors, one means rail above threshold
  typedef struct packed {
    logic analog_rail;
    logic core_rail;
    logic interface_rail;
    logic battery_rail;
    logic power_stage_rail;
  } rail_mon_t;

endpackage

//--- src/amp_power_state_controller.sv
/*
  Power state controller of a digital-input speaker amplifier with an
  AXI4-Lite register slave, sticky masked interrupts and a trim load port.
  Assumes: rail monitors and the reset pin are asynchronous and are
  synchronised here; the trim loader runs on i_clk.
*/
`timescale 1ns/1ps
// How it works
// R1: three states, moves only between neighbours
// R2: enable change reverses a ramp immediately
// R3: fault, supply or reset ramps always complete
// R4: start in hardware shutdown, reset everything
// R5: load trim on exit, flag failure
// R6: reset pin low forces hardware shutdown
// R7: core rail low forces hardware shutdown
// R8: leave hardware shutdown when rails and pin good
// R9: software shutdown: blocks off, registers writable
// R10: enable high goes active, power-up irq
// R11: enable low goes down, power-down irq
// R12: soft reset bit resets into software shutdown
// R13: no activation until battery and power rails good
// R14: battery or power rail low forces shutdown
// R15: manual recovery clears enable, raises irq
// R16: auto recovery keeps enable, restarts later
// R17: host changes only dynamic settings while active; not enforced, every register stays writable while active
// R18: active entered or left only by enable or fault
// R19: sticky flags drive irq through mask
module amp_power_state_controller
  import amp_pwr_pkg::*;
#(
  parameter int TRANS_CYC = TRANS_CYCLES  // ramp length in cycles
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // pins and monitors, asynchronous
  input  wire logic        i_hw_reset_pin_n,
  input  wire rail_mon_t   i_rails,
  // trim loader, same clock
  input  wire logic        i_trim_done,
  input  wire logic        i_trim_ok,
  output logic             o_trim_load_req,
  // power control outputs
  output pwr_state_t       o_state,
  output logic             o_global_reset,
  output logic             o_ctrl_if_en,
  output logic             o_blocks_en,
  output logic             o_irq,
  // axi4-lite write
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  output logic [1:0]       o_s_axi_bresp,
  // axi4-lite read
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  input  wire logic [7:0]  i_s_axi_araddr,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp
);

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; stage one read only by stage two
  logic [5:0] sync1;  // first stage
  logic [5:0] sync2;  // usable stage

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end else begin
      sync1 <= {i_hw_reset_pin_n, i_rails};
      sync2 <= sync1;
    end
  end

  rail_mon_t rails;     // synchronised monitors
  logic      pin_high;  // synchronised reset pin
  logic      core_ok;   // analog, core and interface rails good
  logic      bat_bad;   // battery rail low
  logic      pwr_bad;   // power stage rail low
  assign rails    = sync2[4:0];
  assign pin_high = sync2[5];
  assign core_ok  = rails.analog_rail & rails.core_rail & rails.interface_rail;
  assign bat_bad  = ~rails.battery_rail;
  assign pwr_bad  = ~rails.power_stage_rail;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: address and data latched separately, any order
  logic        aw_hold, next_aw_hold;   // write address taken
  logic [7:0]  aw_addr, next_aw_addr;
  logic        w_hold, next_w_hold;     // write data taken
  logic [31:0] w_data, next_w_data;
  logic        w_lane0, next_w_lane0;   // low byte lane enabled
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0]  rresp, next_rresp;
  logic        wr_fire;                 // write performed this cycle
  logic        bus_live;                // serial interface enabled

  pwr_state_t     state, next_state;
  logic [3:0]     ctrl, next_ctrl;      // en, soft reset (unused), auto bits
  logic [IRQ_W-1:0] irq_st, next_irq_st;
  logic [IRQ_W-1:0] irq_mask, next_irq_mask;

  // mapped only by word address; everything else answers slverr
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_IRQ_STATUS) || (a == OFS_IRQ_MASK);
  endfunction

  assign wr_fire  = aw_hold & w_hold & ~bvalid;
  assign bus_live = (state != ST_HW_SHDN) && (state != ST_TRIM);  // R4

  // bus next values
  always_comb begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold  = w_hold;
    next_w_data  = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    // capture each half when offered
    if (!aw_hold && i_s_axi_awvalid) begin
      next_aw_hold = 1'b1;
      next_aw_addr = i_s_axi_awaddr;
    end
    if (!w_hold && i_s_axi_wvalid) begin
      next_w_hold  = 1'b1;
      next_w_data  = i_s_axi_wdata;
      next_w_lane0 = i_s_axi_wstrb[0];
    end
    // both halves present: answer next cycle
    if (wr_fire) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (bus_live && mapped(aw_addr)) ? RESP_OKAY : RESP_SLVERR;  // R4
    end else if (bvalid && i_s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // reads answer one cycle after the address is taken
    if (rvalid) begin
      if (i_s_axi_rready) begin
        next_rvalid = 1'b0;
      end
    end else if (i_s_axi_arvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = (bus_live && mapped(i_s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
      next_rdata  = 32'h0000_0000;
      if (bus_live) begin
        case (i_s_axi_araddr)
          OFS_CTRL:       next_rdata = {28'h000_0000, ctrl[3:2], 1'b0, ctrl[0]};
          OFS_STATUS:     next_rdata = {21'h00_0000, pin_high, rails, 2'h0, state};
          OFS_IRQ_STATUS: next_rdata = {27'h000_0000, irq_st};
          OFS_IRQ_MASK:   next_rdata = {27'h000_0000, irq_mask};
          default:        next_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // bus registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_hold  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_lane0 <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else begin
      aw_hold <= next_aw_hold;
      aw_addr <= next_aw_addr;
      w_hold  <= next_w_hold;
      w_data  <= next_w_data;
      w_lane0 <= next_w_lane0;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state machine with its registers
  logic [15:0] cnt, next_cnt;          // ramp progress
  logic        forced, next_forced;    // ramp may not be reversed
  logic        trim_bad, next_trim_bad;
  logic [IRQ_W-1:0] ev;                // hardware events this cycle
  logic        wr_ok;                  // accepted register write
  logic        soft_rst;               // soft reset written
  logic        en;                     // current global enable
  logic        next_irq;

  assign wr_ok    = wr_fire & bus_live & w_lane0;
  assign soft_rst = wr_ok && (aw_addr == OFS_CTRL) && w_data[CTRL_SOFT_RST_BIT];  // R12
  assign en       = ctrl[CTRL_EN_BIT];

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_forced   = forced;
    next_trim_bad = trim_bad;
    next_ctrl     = ctrl;
    next_irq_mask = irq_mask;
    next_irq_st   = irq_st;
    ev            = '0;
    // host writes; all registers free in software shutdown
    if (wr_ok && !soft_rst) begin  // R9
      case (aw_addr)
        OFS_CTRL:       next_ctrl = {w_data[3:2], 1'b0, w_data[0]};
        OFS_IRQ_MASK:   next_irq_mask = w_data[IRQ_W-1:0];
        OFS_IRQ_STATUS: next_irq_st = irq_st & ~w_data[IRQ_W-1:0];  // R19
        default:        next_ctrl = ctrl;
      endcase
    end
    case (state)
      ST_HW_SHDN: begin
        if (pin_high && core_ok) begin  // R8
          next_state = ST_TRIM;
        end
      end
      ST_TRIM: begin
        if (i_trim_done) begin  // R5
          next_state    = ST_SW_SHDN;
          next_trim_bad = ~i_trim_ok;
          ev[IRQ_TRIM_BIT] = ~i_trim_ok;
        end
      end
      ST_SW_SHDN: begin
        if (en && !bat_bad && !pwr_bad && !soft_rst) begin  // R10 R13 R16
          next_state  = ST_PWR_UP;
          next_cnt    = 16'h0000;
          next_forced = 1'b0;
        end
      end
      ST_PWR_UP, ST_ACTIVE: begin
        if (bat_bad || pwr_bad || soft_rst) begin  // R14 R3
          next_state  = ST_PWR_DN;
          next_forced = 1'b1;
          next_cnt    = (state == ST_ACTIVE) ? 16'h0000 : 16'(TRANS_CYC - 1) - cnt;
          ev[IRQ_BAT_BIT] = bat_bad;
          ev[IRQ_PWR_BIT] = pwr_bad;
          // manual recovery drops enable; auto keeps it
          if ((bat_bad && !ctrl[CTRL_BAT_AUTO_BIT]) || (pwr_bad && !ctrl[CTRL_PWR_AUTO_BIT])) begin
            next_ctrl[CTRL_EN_BIT] = 1'b0;  // R15
          end
        end else if (!next_ctrl[CTRL_EN_BIT]) begin  // R11 R18
          next_state  = ST_PWR_DN;
          next_forced = 1'b0;
          next_cnt    = (state == ST_ACTIVE) ? 16'h0000 : 16'(TRANS_CYC - 1) - cnt;  // R2
        end else if (state == ST_PWR_UP) begin
          if (cnt == 16'(TRANS_CYC - 1)) begin
            next_state     = ST_ACTIVE;  // R1
            ev[IRQ_UP_BIT] = 1'b1;  // R10
          end else begin
            next_cnt = cnt + 16'h0001;
          end
        end
      end
      ST_PWR_DN: begin
        if (bat_bad || pwr_bad || soft_rst) begin
          next_forced = 1'b1;  // R3
        end
        if (!forced && next_ctrl[CTRL_EN_BIT] && !bat_bad && !pwr_bad && !soft_rst) begin
          next_state = ST_PWR_UP;  // R2
          next_cnt   = 16'(TRANS_CYC - 1) - cnt;
        end else if (cnt == 16'(TRANS_CYC - 1)) begin
          next_state     = ST_SW_SHDN;  // R1
          ev[IRQ_DN_BIT] = ~forced & ~soft_rst;  // R11
        end else begin
          next_cnt = cnt + 16'h0001;
        end
      end
      default: next_state = ST_HW_SHDN;
    endcase
    // soft reset returns registers to defaults, state stays above hw shutdown
    if (soft_rst) begin  // R12
      next_ctrl     = CTRL_RESET;
      next_irq_mask = IRQ_RESET;
      next_irq_st   = IRQ_RESET;
    end
    // events win over clears
    next_irq_st = next_irq_st | ev;  // R19
    // pin or core rails low: hardware shutdown from anywhere
    if (!pin_high || !core_ok || state == ST_HW_SHDN) begin  // R6 R7 R4
      if (!pin_high || !core_ok) begin
        next_state = ST_HW_SHDN;
      end
      next_ctrl     = CTRL_RESET;
      next_irq_mask = IRQ_RESET;
      next_irq_st   = IRQ_RESET;
      next_cnt      = 16'h0000;
      next_forced   = 1'b0;
      next_trim_bad = 1'b0;
    end
    next_irq = |(next_irq_st & next_irq_mask);  // R19
  end

  // state registers and registered outputs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state           <= ST_HW_SHDN;  // R4
      cnt             <= 16'h0000;
      forced          <= 1'b0;
      trim_bad        <= 1'b0;
      ctrl            <= CTRL_RESET;
      irq_mask        <= IRQ_RESET;
      irq_st          <= IRQ_RESET;
      o_irq           <= 1'b0;
      o_state         <= ST_HW_SHDN;
      o_global_reset  <= 1'b1;
      o_ctrl_if_en    <= 1'b0;
      o_blocks_en     <= 1'b0;
      o_trim_load_req <= 1'b0;
    end else begin
      state           <= next_state;
      cnt             <= next_cnt;
      forced          <= next_forced;
      trim_bad        <= next_trim_bad;
      ctrl            <= next_ctrl;
      irq_mask        <= next_irq_mask;
      irq_st          <= next_irq_st;
      o_irq           <= next_irq;
      o_state         <= next_state;
      o_global_reset  <= (next_state == ST_HW_SHDN);  // R4
      o_ctrl_if_en    <= (next_state != ST_HW_SHDN) && (next_state != ST_TRIM);
      o_blocks_en     <= (next_state == ST_ACTIVE);  // R9
      o_trim_load_req <= (next_state == ST_TRIM);  // R5
    end
  end

  // bus outputs straight from flops
  assign o_s_axi_awready = ~aw_hold;
  assign o_s_axi_wready  = ~w_hold;
  assign o_s_axi_bvalid  = bvalid;
  assign o_s_axi_bresp   = bresp;
  assign o_s_axi_arready = ~rvalid;
  assign o_s_axi_rvalid  = rvalid;
  assign o_s_axi_rdata   = rdata;
  assign o_s_axi_rresp   = rresp;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_NEIGHBOUR: assert property ((state == ST_SW_SHDN) |=> state inside {ST_SW_SHDN, ST_PWR_UP, ST_HW_SHDN}) // R1
    else $error("software shutdown left for a non-neighbour");
  AST_REVERSE: assert property ((state == ST_PWR_UP && !forced && !bat_bad && !pwr_bad && pin_high && core_ok
      && wr_ok && aw_addr == OFS_CTRL && !w_data[CTRL_EN_BIT]) |=> state == ST_PWR_DN) // R2
    else $error("ramp up not reversed by enable drop");
  AST_NO_REVERSE: assert property ((state == ST_PWR_DN && forced && pin_high && core_ok) |=> state != ST_PWR_UP) // R3
    else $error("forced ramp was reversed");
  AST_HW_CLEAR: assert property ((state == ST_HW_SHDN) |=> (ctrl == CTRL_RESET && irq_st == IRQ_RESET)) // R4
    else $error("registers not cleared in hardware shutdown");
  AST_TRIM_IRQ: assert property ((state == ST_TRIM && i_trim_done && !i_trim_ok && pin_high && core_ok)
      |=> (state == ST_SW_SHDN && irq_st[IRQ_TRIM_BIT])) // R5
    else $error("trim failure not flagged");
  AST_PIN_LOW: assert property ((!pin_high) |=> (state == ST_HW_SHDN && o_state == ST_HW_SHDN)) // R6
    else $error("reset pin did not force hardware shutdown");
  AST_CORE_LOW: assert property ((!core_ok) |=> (state == ST_HW_SHDN && !o_ctrl_if_en)) // R7
    else $error("core rail loss did not force hardware shutdown");
  AST_EXIT_HW: assert property ((state == ST_HW_SHDN) ##1 (state == ST_TRIM) |-> $past(pin_high) && $past(core_ok)) // R8
    else $error("hardware shutdown left without good conditions");
  AST_BLOCKS_OFF: assert property ((state == ST_SW_SHDN) |-> !o_blocks_en) // R9
    else $error("blocks enabled in software shutdown");
  AST_UP_IRQ: assert property ((state == ST_PWR_UP) ##1 (state == ST_ACTIVE) |-> irq_st[IRQ_UP_BIT]) // R10
    else $error("power up done not flagged");
  AST_DN_IRQ: assert property ((state == ST_PWR_DN && !forced && !soft_rst) ##1 (state == ST_SW_SHDN)
      |-> irq_st[IRQ_DN_BIT]) // R11
    else $error("power down done not flagged");
  AST_SOFT_RST: assert property ((soft_rst && pin_high && core_ok)
      |=> (state inside {ST_SW_SHDN, ST_PWR_DN} && ctrl == CTRL_RESET)) // R12
    else $error("soft reset did not reset into software shutdown");
  AST_SUPPLY_GATE: assert property ((state == ST_SW_SHDN) ##1 (state == ST_PWR_UP) |-> !$past(bat_bad) && !$past(pwr_bad)) // R13
    else $error("ramp up with supply low");
  AST_FAULT_DN: assert property ((state == ST_ACTIVE && bat_bad && pin_high && core_ok)
      |=> (state == ST_PWR_DN && irq_st[IRQ_BAT_BIT])) // R14
    else $error("battery loss did not force shutdown");
  AST_MANUAL: assert property ((state == ST_ACTIVE && pin_high && core_ok
      && ((bat_bad && !ctrl[CTRL_BAT_AUTO_BIT]) || (pwr_bad && !ctrl[CTRL_PWR_AUTO_BIT]))) |=> !en) // R15
    else $error("manual recovery kept enable");
  AST_AUTO: assert property ((state == ST_ACTIVE && (bat_bad || pwr_bad) && (!bat_bad || ctrl[CTRL_BAT_AUTO_BIT])
      && (!pwr_bad || ctrl[CTRL_PWR_AUTO_BIT]) && en && pin_high && core_ok && !wr_ok) |=> en) // R16
    else $error("auto recovery dropped enable");
  AST_ACTIVE_ENTRY: assert property ($rose(state == ST_ACTIVE) |-> $past(state) == ST_PWR_UP) // R18
    else $error("active entered not from ramp up");
  AST_IRQ_OUT: assert property (o_irq == (|(irq_st & irq_mask))) // R19
    else $error("unmasked flag not on interrupt");

  COV_UP:     cover property ((state == ST_PWR_UP) ##1 (state == ST_ACTIVE));
  COV_FLIP:   cover property ((state == ST_PWR_UP) ##1 (state == ST_PWR_DN) ##1 (state == ST_PWR_DN));
  COV_AUTO:   cover property ((state == ST_PWR_DN && forced && en) ##[1:300] (state == ST_PWR_UP));
  COV_TRIMNG: cover property ((state == ST_TRIM) ##1 (state == ST_SW_SHDN && trim_bad));

endmodule // amp_power_state_controller

//--- verif/trim_loader_model.sv
/*
  Model of the trim storage loader that sits beside the controller.
  Assumes the requester holds i_req high until done has been seen.
*/
`timescale 1ns/1ps
module trim_loader_model #(
  parameter int DELAY = 3  // counted request cycles; done comes DELAY+1 cycles after request
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // load handshake
  input  wire logic i_req,   // load request from the controller
  input  wire logic i_fail,  // bench asks for a failed load
  output logic      o_done,  // one-cycle completion
  output logic      o_ok     // result, valid with done only
);
  int cnt;  // cycles spent on this request

  ////////////////////////////////////////////////////////////////////////////
  // answer once per request; result toggles when not valid, so stale reads show
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt    <= 0;
      o_done <= 1'h0;
      o_ok   <= 1'h0;
    end else begin
      o_done <= i_req && (cnt == DELAY);
      o_ok   <= (i_req && cnt == DELAY) ? ~i_fail : ~o_ok;
      cnt    <= i_req ? cnt + 1 : 0;
    end
  end
endmodule // trim_loader_model

//--- verif/amp_power_state_controller_test.sv
/*
  Self-checking bench for amp_power_state_controller: axi4-lite host,
  rail monitors, reset pin. Assumes trim_loader_model answers trim loads.
*/
`timescale 1ns/1ps
module amp_power_state_controller_test
  import amp_pwr_pkg::*;
;
  logic        clk = 0, rst_n = 0, pin_n = 0, fail = 1;  // clock, resets, trim fault select
  logic        req, done, ok, grst, ifen, blen, irq;       // loader and power outputs
  rail_mon_t   rails = '1;                                 // all rails good
  pwr_state_t  state;                                      // observed power state
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0]  bresp, rresp;
  logic [33:0] exp_q[$];                                   // expected {resp, data}
  int          n_errors = 0, n_compared = 0;

  always #5 clk = ~clk;

  amp_power_state_controller #(.TRANS_CYC(16)) u_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_hw_reset_pin_n(pin_n), .i_rails(rails),
    .i_trim_done(done), .i_trim_ok(ok), .o_trim_load_req(req), .o_state(state),
    .o_global_reset(grst), .o_ctrl_if_en(ifen), .o_blocks_en(blen), .o_irq(irq),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp));

  trim_loader_model u_trim (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_fail(fail), .o_done(done), .o_ok(ok));

  ////////////////////////////////////////////////////////////////////////////
  // compare, verdict, bounded waits
  task automatic check(input string nm, input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic bound(input int k);
    if (k >= 50) begin
      check("handshake timeout", 34'h1, 34'h0);
      print_verdict();
    end
  endtask

  // poll the state; a miss after the bound ends the run
  task automatic wait_st(input pwr_state_t s);
    int k;
    for (k = 0; k < 500 && state !== s; k++) @(posedge clk);
    check("state", 34'(state), 34'(s));
    if (state !== s) print_verdict();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite master; a spare edge after release avoids double assignment
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    repeat ($urandom_range(0, 3)) @(posedge clk);
    awvalid <= 1'h1;
    awaddr  <= a;
    wvalid  <= 1'h1;
    wdata   <= d;
    bready  <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    check("bresp", 34'(bresp), 34'(RESP_OKAY));
    bready <= 1'h0;
    @(posedge clk);
    bound(k);
  endtask

  // the watcher below compares the answer against the queued note
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int k;
    repeat ($urandom_range(0, 3)) @(posedge clk);
    exp_q.push_back(e);
    arvalid <= 1'h1;
    araddr  <= a;
    rready  <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rready <= 1'h0;
    @(posedge clk);
    bound(k);
  endtask

  // read answer watcher
  always @(posedge clk) begin
    if (rvalid && rready) check("read", {rresp, rdata}, exp_q.pop_front());
  end

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  initial begin
    int k;
    void'($urandom(94030));
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    repeat (6) @(posedge clk);
    wait_st(ST_HW_SHDN);
    check("grst", 34'(grst), 34'h1);
    check("ifen", 34'(ifen), 34'h0);
    rd(OFS_CTRL, {RESP_SLVERR, 32'h0});
    pin_n <= 1'h1;
    wait_st(ST_SW_SHDN);
    check("ifen", 34'(ifen), 34'h1);
    rd(OFS_IRQ_STATUS, {RESP_OKAY, 32'h10});
    wr(OFS_IRQ_STATUS, 32'h1F);
    wr(OFS_IRQ_MASK, 32'h1F);
    rd(8'h10, {RESP_SLVERR, 32'h0});
    $display("test boot done");
    rails.battery_rail <= 1'h0;
    wr(OFS_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    wait_st(ST_SW_SHDN);
    rails.battery_rail <= 1'h1;
    wait_st(ST_ACTIVE);
    rd(OFS_IRQ_STATUS, {RESP_OKAY, 32'h1});
    check("irq", 34'(irq), 34'h1);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h1);
    wait_st(ST_ACTIVE);
    wr(OFS_IRQ_STATUS, 32'h1);
    rd(OFS_IRQ_STATUS, {RESP_OKAY, 32'h0});
    check("irq", 34'(irq), 34'h0);
    wr(OFS_CTRL, 32'h0);
    wait_st(ST_SW_SHDN);
    check("blocks", 34'(blen), 34'h0);
    rd(OFS_IRQ_STATUS, {RESP_OKAY, 32'h2});
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CTRL, 32'h0);
    wait_st(ST_SW_SHDN);
    rd(OFS_IRQ_STATUS, {RESP_OKAY, 32'h2});
    $display("test enable done");
    wr(OFS_CTRL, 32'h1);
    wait_st(ST_ACTIVE);
    wr(OFS_IRQ_STATUS, 32'h1F);
    rails.battery_rail <= 1'h0;
    wait_st(ST_SW_SHDN);
    rails.battery_rail <= 1'h1;
    repeat (20) @(posedge clk);
    wait_st(ST_SW_SHDN);
    rd(OFS_CTRL, {RESP_OKAY, 32'h0});
    rd(OFS_IRQ_STATUS, {RESP_OKAY, 32'h4});
    wr(OFS_CTRL, 32'h9);
    wait_st(ST_ACTIVE);
    wr(OFS_IRQ_STATUS, 32'h1F);
    rails.power_stage_rail <= 1'h0;
    wait_st(ST_SW_SHDN);
    rd(OFS_CTRL, {RESP_OKAY, 32'h9});
    rd(OFS_IRQ_STATUS, {RESP_OKAY, 32'h8});
    rails.power_stage_rail <= 1'h1;
    wait_st(ST_ACTIVE);
    $display("test recovery done");
    wr(OFS_CTRL, 32'h2);
    wait_st(ST_SW_SHDN);
    rd(OFS_CTRL, {RESP_OKAY, 32'h0});
    rd(OFS_IRQ_MASK, {RESP_OKAY, 32'h0});
    wr(OFS_CTRL, 32'h1);
    wait_st(ST_ACTIVE);
    k = $urandom_range(0, 2);
    rails[2 + k] <= 1'h0;
    fail <= 1'($urandom_range(0, 1));
    wait_st(ST_HW_SHDN);
    rd(OFS_CTRL, {RESP_SLVERR, 32'h0});
    rails <= '1;
    wait_st(ST_SW_SHDN);
    rd(OFS_IRQ_STATUS, {RESP_OKAY, (fail ? 32'h10 : 32'h0)});
    rd(OFS_CTRL, {RESP_OKAY, 32'h0});
    wr(OFS_CTRL, 32'h1);
    wait_st(ST_ACTIVE);
    pin_n <= 1'h0;
    wait_st(ST_HW_SHDN);
    $display("test faults done");
    print_verdict();
  end
endmodule // amp_power_state_controller_test
